//--- rtl/hpb_regs.svh
// Purpose: constants for the host processor bus port
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: bus style is a strap input sampled every cycle
//
// Overview of operation
// - Sixteen-bit shared data bus, device drives reads
// - Twelve-bit word address selects internal location
// - Direction line: low writes, high reads
// - Write strobe low captures write data
// - Read strobe low returns addressed data
// - Chip select high ignores all bus inputs
// - Interrupt pulled low while condition pending
`ifndef HPB_REGS_SVH
`define HPB_REGS_SVH

`define HPB_DATA_W 16
`define HPB_ADDR_W 12
`define HPB_SYNC_ZERO 3'h0
`define HPB_DATA_ZERO 16'h0000
`define HPB_ADDR_ZERO 12'h000
`define HPB_CTL_BITS 3
`define HPB_CTL_IDLE 3'h7

`endif

//--- rtl/hpb_pkg.sv
// Purpose: types for the host processor bus port
// Assumes: constants come from hpb_regs.svh
// Notes: none
`include "hpb_regs.svh"

package hpb_pkg;

	typedef enum logic [2:0] {
		HPB_IDLE = 3'b001,
		HPB_WRITE = 3'b010,
		HPB_READ = 3'b100
	} hpb_state_t;

	// Pins after synchronisation
	typedef struct packed {
		logic cs_n;
		logic rw_n;
		logic oe_n;
	} hpb_ctl_t;

	// Request toward the internal register space
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`HPB_ADDR_W-1:0] addr;
		logic [`HPB_DATA_W-1:0] wdata;
	} hpb_req_t;

endpackage

//--- rtl/hpb_port.sv
// Purpose: processor port bridging a parallel bus to internal registers
// Assumes: pins are asynchronous; address and data are stable while a strobe is low
// Notes: one internal write or read request per processor access
`timescale 1ns/1ps
`include "hpb_regs.svh"

module hpb_port (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic NRST,
	// Bus style: 1 separate strobes, 0 direction line
	input wire logic STROBE_MODE,
	// Processor bus pins
	input wire logic UP_CS_N,
	input wire logic UP_RW_N,
	input wire logic UP_OE_N,
	input wire logic [`HPB_ADDR_W-1:0] UP_ADDR,
	input wire logic [`HPB_DATA_W-1:0] UP_DATA_IN,
	output logic [`HPB_DATA_W-1:0] UP_DATA_OUT,
	output logic UP_DATA_OE_N,
	output logic UP_IRQ_OUT,
	output logic UP_IRQ_OE_N,
	// Internal register space
	output logic REG_WR,
	output logic REG_RD,
	output logic [`HPB_ADDR_W-1:0] REG_ADDR,
	output logic [`HPB_DATA_W-1:0] REG_WDATA,
	input wire logic [`HPB_DATA_W-1:0] REG_RDATA,
	input wire logic IRQ_PENDING
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Raw pins, gathered so the three stages treat them alike
	hpb_pkg::hpb_ctl_t ctl_raw;
	// First stage may go metastable; only the second stage reads it
	hpb_pkg::hpb_ctl_t s1_reg;
	hpb_pkg::hpb_ctl_t s2_reg;
	hpb_pkg::hpb_ctl_t s3_reg;
	// Filtered pin levels that the decode acts on
	hpb_pkg::hpb_ctl_t ctl_reg;
	hpb_pkg::hpb_ctl_t ctl_next;
	// Access sequencer
	hpb_pkg::hpb_state_t state_reg;
	hpb_pkg::hpb_state_t state_next;
	// Processor side
	logic [`HPB_DATA_W-1:0] dout_reg;
	logic oe_n_reg;
	logic irq_oe_n_reg;
	logic irq_out_reg;
	// Register side
	logic wr_reg;
	logic rd_reg;
	logic [`HPB_ADDR_W-1:0] addr_reg;
	logic [`HPB_DATA_W-1:0] wdata_reg;
	hpb_pkg::hpb_req_t req_next;

	assign ctl_raw = '{cs_n: UP_CS_N, rw_n: UP_RW_N, oe_n: UP_OE_N};

	// Change accepted only when second and third stages agree
	genvar i;
	generate
		for (i = 0; i < `HPB_CTL_BITS; i++) begin : g_filt
			assign ctl_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : ctl_reg[i];
		end
	endgenerate

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			s1_reg <= `HPB_CTL_IDLE;
			s2_reg <= `HPB_CTL_IDLE;
			s3_reg <= `HPB_CTL_IDLE;
			ctl_reg <= `HPB_CTL_IDLE;
		end else begin
			s1_reg <= ctl_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			ctl_reg <= ctl_next;
		end
	end

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	// Low on the shared direction/write pin is a write in either style
	function automatic logic write_cond(input hpb_pkg::hpb_ctl_t c);
		write_cond = !c.rw_n;
	endfunction

	// Read strobe in strobe style, high direction line otherwise;
	// a low write strobe masks it, so a write wins when both are low
	function automatic logic read_cond(input logic strobe_mode, input hpb_pkg::hpb_ctl_t c);
		if (strobe_mode)
			read_cond = !c.oe_n && c.rw_n;
		else
			read_cond = c.rw_n;
	endfunction

	// Direction-line style ignores the output enable, which the system grounds
	wire sel = !ctl_reg.cs_n;
	wire wr_req = sel && write_cond(ctl_reg);
	wire rd_req = sel && read_cond(STROBE_MODE, ctl_reg);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			hpb_pkg::HPB_IDLE: begin
				if (wr_req)
					state_next = hpb_pkg::HPB_WRITE;
				else if (rd_req)
					state_next = hpb_pkg::HPB_READ;
			end
			hpb_pkg::HPB_WRITE: begin
				if (!wr_req)
					state_next = hpb_pkg::HPB_IDLE;
			end
			hpb_pkg::HPB_READ: begin
				if (!rd_req)
					state_next = hpb_pkg::HPB_IDLE;
			end
			default: state_next = hpb_pkg::HPB_IDLE;
		endcase
	end

	wire start_wr = (state_reg == hpb_pkg::HPB_IDLE) && wr_req;
	wire start_rd = (state_reg == hpb_pkg::HPB_IDLE) && !wr_req && rd_req;
	wire in_read = (state_reg == hpb_pkg::HPB_READ) && rd_req;

	// Address and data pins are taken unsynchronised, so the processor
	// must hold them stable while its strobe is low
	assign req_next = '{wr: start_wr, rd: start_rd, addr: UP_ADDR, wdata: UP_DATA_IN};

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!NRST)
			state_reg <= hpb_pkg::HPB_IDLE;
		else
			state_reg <= state_next;
	end

	// ----------------------------------------
	// Register side
	// ----------------------------------------
	// One pulse per strobe assertion; the sequencer blocks a repeat until release
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
		end else begin
			wr_reg <= req_next.wr;
			rd_reg <= req_next.rd;
		end
	end

	// Address and data are taken after the strobe settles, so they are stable by then
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			addr_reg <= `HPB_ADDR_ZERO;
			wdata_reg <= `HPB_DATA_ZERO;
		end else begin
			if (req_next.wr || req_next.rd)
				addr_reg <= req_next.addr;
			if (req_next.wr)
				wdata_reg <= req_next.wdata;
		end
	end

	// ----------------------------------------
	// Processor data bus
	// ----------------------------------------
	// Register space answers in the pulse cycle; the word is held from the next edge
	always_ff @(posedge CLOCK) begin
		if (!NRST)
			dout_reg <= `HPB_DATA_ZERO;
		else if (rd_reg)
			dout_reg <= REG_RDATA;
	end

	// Word and enable change on the same edge, so the bus never shows a stale word
	always_ff @(posedge CLOCK) begin
		if (!NRST)
			oe_n_reg <= 1'b1;
		else
			oe_n_reg <= !in_read;
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	// Open drain: the level stays low and only the enable moves;
	// released, the line rises through the board pull-up
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			irq_out_reg <= 1'b0;
			irq_oe_n_reg <= 1'b1;
		end else begin
			irq_out_reg <= 1'b0;
			irq_oe_n_reg <= !IRQ_PENDING;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign UP_DATA_OUT = dout_reg;
	assign UP_DATA_OE_N = oe_n_reg;
	assign UP_IRQ_OUT = irq_out_reg;
	assign UP_IRQ_OE_N = irq_oe_n_reg;
	assign REG_WR = wr_reg;
	assign REG_RD = rd_reg;
	assign REG_ADDR = addr_reg;
	assign REG_WDATA = wdata_reg;

endmodule

//--- verif/hpb_port_asserts.sv
// Purpose: timing checks on the processor port
// Assumes: pins stay stable through an access
// Notes: bound into every hpb_port
`timescale 1ns/1ps
`include "hpb_regs.svh"
module hpb_port_asserts (
	input wire logic CLOCK, NRST, STROBE_MODE, UP_CS_N, UP_RW_N,
	input wire logic UP_DATA_OE_N, UP_IRQ_OE_N, REG_WR, REG_RD, IRQ_PENDING,
	input wire logic [`HPB_ADDR_W-1:0] UP_ADDR, REG_ADDR,
	input wire logic [`HPB_DATA_W-1:0] UP_DATA_IN, UP_DATA_OUT, REG_WDATA, REG_RDATA
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	rd_data_a: assert property (REG_RD |=> !UP_DATA_OE_N && UP_DATA_OUT == $past(REG_RDATA))
		else $error("bad read data");
	wr_cap_a: assert property (REG_WR |-> REG_WDATA == $past(UP_DATA_IN) && !$past(UP_RW_N))
		else $error("bad write");
	addr_a: assert property (REG_WR || REG_RD |-> REG_ADDR == $past(UP_ADDR))
		else $error("bad address");
	dir_rd_a: assert property (REG_RD && !STROBE_MODE |-> $past(UP_RW_N))
		else $error("bad direction");
	one_pulse_a: assert property (REG_WR || REG_RD |=> !REG_WR && !REG_RD)
		else $error("long pulse");
	cs_ign_a: assert property (UP_CS_N [*6] |-> !REG_WR && !REG_RD && UP_DATA_OE_N)
		else $error("acted while deselected");
	drive_rd_a: assert property ($fell(UP_DATA_OE_N) |-> $past(REG_RD))
		else $error("drove bus unasked");
	irq_a: assert property (##1 UP_IRQ_OE_N == !$past(IRQ_PENDING))
		else $error("bad irq");
	cover property (REG_WR && STROBE_MODE);
	cover property (REG_RD && !STROBE_MODE);
	cover property ($fell(UP_IRQ_OE_N));
endmodule
bind hpb_port hpb_port_asserts i_hpb_port_asserts (.*);

//--- verif/hpb_cpu.sv
// Purpose: local processor model on the port pins
// Assumes: one access at a time, held 8 cycles
// Notes: a released data bus shows the inverse word
`timescale 1ns/1ps
`include "hpb_regs.svh"
module hpb_cpu (
	input wire logic CLOCK, STROBE_MODE, UP_DATA_OE_N,
	input wire logic [`HPB_DATA_W-1:0] UP_DATA_OUT,
	output logic UP_CS_N, UP_RW_N, UP_OE_N,
	output logic [`HPB_ADDR_W-1:0] UP_ADDR,
	output logic [`HPB_DATA_W-1:0] UP_DATA_IN
);
	initial {UP_CS_N, UP_RW_N, UP_OE_N, UP_ADDR, UP_DATA_IN} = {3'h7, 12'h000, 16'h0000};
	task automatic acc(input logic c, r, o, input logic [`HPB_ADDR_W-1:0] a,
		input logic [`HPB_DATA_W-1:0] d, output logic [`HPB_DATA_W-1:0] q);
		@(posedge CLOCK) #1 {UP_CS_N, UP_RW_N, UP_OE_N, UP_ADDR, UP_DATA_IN} = {c, r, o, a, d};
		repeat (8) @(posedge CLOCK);
		#1 q = UP_DATA_OE_N ? ~UP_DATA_IN : UP_DATA_OUT;
		{UP_CS_N, UP_RW_N, UP_OE_N, UP_DATA_IN} = {2'h3, STROBE_MODE, ~d};
		repeat (6) @(posedge CLOCK);
	endtask
endmodule

//--- verif/hpb_port_tb.sv
// Purpose: self-checking bench for hpb_port
// Assumes: register space answers address xor 16'h5a5a
// Notes: pins come from hpb_cpu
`timescale 1ns/1ps
`include "hpb_regs.svh"
module hpb_port_tb;
	logic CLOCK, NRST, STROBE_MODE, IRQ_PENDING, UP_CS_N, UP_RW_N, UP_OE_N, UP_DATA_OE_N;
	logic UP_IRQ_OUT, UP_IRQ_OE_N, REG_WR, REG_RD;
	logic [`HPB_ADDR_W-1:0] UP_ADDR, REG_ADDR;
	logic [`HPB_DATA_W-1:0] UP_DATA_IN, UP_DATA_OUT, REG_WDATA, REG_RDATA, wr_seen, q;
	int mismatches = 0, checks_done = 0, wr_count = 0;
	assign REG_RDATA = {4'h0, REG_ADDR} ^ 16'h5a5a;
	hpb_port i_hpb_port (.*);
	hpb_cpu i_hpb_cpu (.*);
	always @(posedge CLOCK) #1 if (REG_WR === 1'b1) begin
		wr_count++;
		wr_seen = REG_WDATA;
	end
	task automatic check(input string n, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic t_wr(input logic m, input logic [11:0] a, input logic [15:0] d);
		int n;
		n = wr_count;
		#1 STROBE_MODE = m;
		i_hpb_cpu.acc(1'b0, 1'b0, m, a, d, q);
		check("writes", 16'h0001, 16'(wr_count - n));
		check("wdata", d, wr_seen);
		check("waddr", {4'h0, a}, {4'h0, REG_ADDR});
	endtask
	task automatic t_rd(input logic m, input logic [11:0] a);
		#1 STROBE_MODE = m;
		i_hpb_cpu.acc(1'b0, 1'b1, 1'b0, a, 16'h0000, q);
		check("rdata", {4'h0, a} ^ 16'h5a5a, q);
	endtask
	task automatic t_cs;
		int n;
		n = wr_count;
		i_hpb_cpu.acc(1'b1, 1'b0, 1'b0, 12'h3c3, 16'h1234, q);
		check("deselected", 16'h0000, 16'(wr_count - n));
	endtask
	task automatic t_irq;
		#1 IRQ_PENDING = 1'b1;
		repeat (2) @(posedge CLOCK);
		#1 check("irq low", 16'h0000, {14'h0, UP_IRQ_OUT, UP_IRQ_OE_N});
		IRQ_PENDING = 1'b0;
		repeat (2) @(posedge CLOCK);
		#1 check("irq free", 16'h0001, {14'h0, UP_IRQ_OUT, UP_IRQ_OE_N});
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	initial begin
		{NRST, STROBE_MODE, IRQ_PENDING} = 3'h0;
		repeat (8) @(posedge CLOCK);
		#1 NRST = 1'b1;
		repeat (4) @(posedge CLOCK);
		t_wr(1'b1, 12'hfff, 16'ha5c3);
		t_rd(1'b1, 12'hfff);
		t_wr(1'b0, 12'h000, 16'hffff);
		t_rd(1'b0, 12'h801);
		t_cs;
		t_irq;
		test_done;
	end
endmodule
